// ### core/smsr_crc16.sv
// Purpose: crc-16 engine over the stream of programmed setting words
// Assumes: one 24-bit setting word per strobe, msb first, same clock as caller
// Notes: polynomial 1021h, seed all ones, result bit 0 is the crc lsb
module smsr_crc16
  import smsr_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic word_valid,
  input wire logic [SMSR_DW-1:0] word,
  output logic [SMSR_CW-1:0] crc
);

  ////////////////////////////////////////////////////////////////////////////
  // one whole word folded in a single cycle; the settings change rarely
  // so the wide xor tree costs less than a serial engine and its control
  function automatic logic [SMSR_CW-1:0] crc_word(input logic [SMSR_CW-1:0] c_in,
                                                  input logic [SMSR_DW-1:0] d);
    logic [SMSR_CW-1:0] c;
    logic fb;
    c = c_in;
    fb = 1'b0;
    for (int i = SMSR_DW - 1; i >= 0; i--)
    begin
      fb = c[SMSR_CW-1] ^ d[i];
      c = {c[SMSR_CW-2:0], 1'b0};
      if (fb)
      begin
        c = c ^ SMSR_CRC_POLY;
      end
    end
    return c;
  endfunction

  logic [SMSR_CW-1:0] crc_r;
  logic [SMSR_CW-1:0] crc_nxt;

  // clear restarts from the seed and wins over a word in the same cycle
  assign crc_nxt = clear ? SMSR_CRC_RESET : crc_word(crc_r, word);

  // result register, all ones after reset
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      crc_r <= SMSR_CRC_RESET;
    else if (clear || word_valid)
      crc_r <= crc_nxt;
  end

  assign crc = crc_r;

endmodule

// ### core/smsr_pkg.sv
// Purpose: shared constants of the switch monitor status register bank
// Assumes: 24-bit registers reached through a 32-bit serial frame
// Notes: frame layout is write flag, 6-bit address, 24-bit data, odd parity bit
package smsr_pkg;
  localparam int SMSR_DW = 24;
  localparam int SMSR_AW = 6;
  localparam int SMSR_CW = 16;
  localparam int SMSR_FRAME_BITS = 32;
  localparam int SMSR_SYNC_STAGES = 2;
  // register offsets
  localparam logic [5:0] SMSR_REG_CHECKSUM = 6'h03;
  localparam logic [5:0] SMSR_REG_LIVE = 6'h04;
  localparam logic [5:0] SMSR_REG_THRESH = 6'h05;
  // reset values and crc polynomial
  localparam logic [15:0] SMSR_CRC_RESET = 16'hFFFF;
  localparam logic [15:0] SMSR_CRC_POLY = 16'h1021;
  localparam logic [23:0] SMSR_LIVE_RESET = 24'h000000;
  localparam logic [23:0] SMSR_THRESH_RESET = 24'h000000;
  // live status field positions
  localparam int SMSR_LIVE_LOW_BIT = 3;
  localparam int SMSR_LIVE_HIGH_BIT = 2;
  localparam int SMSR_LIVE_WARN_BIT = 1;
  localparam int SMSR_LIVE_SHUT_BIT = 0;
  // frame field positions
  localparam int SMSR_FRM_WR_BIT = 31;
  localparam int SMSR_FRM_ADDR_HI = 30;
  localparam int SMSR_FRM_ADDR_LO = 25;
  localparam int SMSR_FRM_DATA_HI = 24;
  localparam int SMSR_FRM_DATA_LO = 1;
  // response status byte field positions and bit counter limits
  localparam int SMSR_STAT_LEN_BIT = 7;
  localparam int SMSR_STAT_PAR_BIT = 6;
  localparam logic [5:0] SMSR_CNT_FRAME = 6'h20;
  localparam logic [5:0] SMSR_CNT_MAX = 6'h21;
  typedef enum logic [0:0] {
    SMSR_IDLE = 1'b0,
    SMSR_FRAME = 1'b1
  } smsr_state_t;
endpackage

// ### core/smsr_status_regs.sv
// Purpose: read-only checksum, supply/thermal and input threshold registers
// Assumes: serial pins and analog flags are asynchronous to clk
// Notes: read data of one frame is returned in the next frame
////////////////////////////////////////////////////////////////////////////
module smsr_status_regs
  import smsr_pkg::*;
#(
  parameter int NUM_INPUTS = 24
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe,
  input wire logic supply_low_live,
  input wire logic supply_high_live,
  input wire logic heat_warning_live,
  input wire logic heat_shutdown_live,
  input wire logic [NUM_INPUTS-1:0] switch_above,
  input wire logic settings_restart,
  input wire logic settings_valid,
  input wire logic [SMSR_DW-1:0] settings_word,
  output logic frame_len_error,
  output logic frame_par_error
);

  // refuse an input count that the 24-bit threshold register cannot hold
  if (NUM_INPUTS < 1 || NUM_INPUTS > SMSR_DW)
  begin : g_bad_width
    $error("NUM_INPUTS must lie between 1 and 24");
  end

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer and parity; only the parity is used by more than one path
  function automatic logic [SMSR_DW-1:0] reg_read(input logic [SMSR_AW-1:0] a,
                                                  input logic [SMSR_CW-1:0] c,
                                                  input logic [SMSR_DW-1:0] l,
                                                  input logic [SMSR_DW-1:0] t);
    logic [SMSR_DW-1:0] v;
    v = '0;
    unique case (a)
      SMSR_REG_CHECKSUM: v = {8'h00, c};
      SMSR_REG_LIVE: v = l;
      SMSR_REG_THRESH: v = t;
      default: v = '0;
    endcase
    return v;
  endfunction

  function automatic logic odd_ok(input logic [SMSR_FRAME_BITS-1:0] f);
    return ^f;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-flop synchronisers; a third stage on sclk gives edge detection
  logic [1:0] cs_s_r;
  logic [1:0] si_s_r;
  logic [2:0] sclk_s_r;
  logic [1:0] low_s_r;
  logic [1:0] high_s_r;
  logic [1:0] warn_s_r;
  logic [1:0] shut_s_r;
  logic [NUM_INPUTS-1:0] thr_s1_r;
  logic [NUM_INPUTS-1:0] thr_s2_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cs_s_r <= 2'h3;
      si_s_r <= 2'h0;
      sclk_s_r <= 3'h0;
      low_s_r <= 2'h0;
      high_s_r <= 2'h0;
      warn_s_r <= 2'h0;
      shut_s_r <= 2'h0;
      thr_s1_r <= '0;
      thr_s2_r <= '0;
    end
    else
    begin
      cs_s_r <= {cs_s_r[0], spi_cs_n};
      si_s_r <= {si_s_r[0], spi_si};
      sclk_s_r <= {sclk_s_r[1:0], spi_sclk};
      low_s_r <= {low_s_r[0], supply_low_live};
      high_s_r <= {high_s_r[0], supply_high_live};
      warn_s_r <= {warn_s_r[0], heat_warning_live};
      shut_s_r <= {shut_s_r[0], heat_shutdown_live};
      thr_s1_r <= switch_above;
      thr_s2_r <= thr_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // live registers follow the conditions every cycle except a soft reset cycle; no read or write path
  // touches them, so a read never clears a condition
  logic [SMSR_DW-1:0] live_r;
  logic [SMSR_DW-1:0] thresh_r;
  logic [SMSR_DW-1:0] live_nxt;
  logic [SMSR_DW-1:0] thresh_nxt;

  always_comb
  begin
    live_nxt = SMSR_LIVE_RESET;
    live_nxt[SMSR_LIVE_LOW_BIT] = low_s_r[1];
    live_nxt[SMSR_LIVE_HIGH_BIT] = high_s_r[1];
    live_nxt[SMSR_LIVE_WARN_BIT] = warn_s_r[1];
    live_nxt[SMSR_LIVE_SHUT_BIT] = shut_s_r[1];
    thresh_nxt = SMSR_THRESH_RESET;
    thresh_nxt[NUM_INPUTS-1:0] = thr_s2_r;
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      live_r <= SMSR_LIVE_RESET;
      thresh_r <= SMSR_THRESH_RESET;
    end
    else if (soft_reset)
    begin
      live_r <= SMSR_LIVE_RESET;
      thresh_r <= SMSR_THRESH_RESET;
    end
    else
    begin
      live_r <= live_nxt;
      thresh_r <= thresh_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checksum over the setting words; soft reset reseeds it
  logic [SMSR_CW-1:0] crc_val;

  smsr_crc16 u_crc (
    .clk(clk),
    .rstn(rstn),
    .clear(settings_restart || soft_reset),
    .word_valid(settings_valid),
    .word(settings_word),
    .crc(crc_val)
  );

  ////////////////////////////////////////////////////////////////////////////
  // frame tracking on the sampled serial clock
  wire cs_act = !cs_s_r[1];
  wire sclk_rise = sclk_s_r[1] && !sclk_s_r[2];
  wire sclk_fall = !sclk_s_r[1] && sclk_s_r[2];

  smsr_state_t state_r;
  smsr_state_t state_nxt;
  logic [5:0] cnt_r;
  logic [SMSR_FRAME_BITS-1:0] rx_r;
  logic [SMSR_FRAME_BITS-1:0] tx_r;
  logic [SMSR_DW-1:0] rdata_r;
  logic len_flag_r;
  logic par_flag_r;
  logic so_r;
  logic len_err_r;
  logic par_err_r;

  wire frame_start = (state_r == SMSR_IDLE) && cs_act;
  wire frame_end = (state_r == SMSR_FRAME) && !cs_act;
  // a frame with no clock at all is not an error
  wire len_bad = frame_end && (cnt_r != SMSR_CNT_FRAME) && (cnt_r != 6'h00);
  wire par_bad = frame_end && (cnt_r == SMSR_CNT_FRAME) && !odd_ok(rx_r);
  wire frame_ok = frame_end && (cnt_r == SMSR_CNT_FRAME) && odd_ok(rx_r);
  wire is_write = rx_r[SMSR_FRM_WR_BIT];
  wire [SMSR_AW-1:0] rx_addr = rx_r[SMSR_FRM_ADDR_HI:SMSR_FRM_ADDR_LO];
  wire [SMSR_DW-1:0] rd_val = reg_read(rx_addr, crc_val, live_r, thresh_r);
  wire [7:0] stat_byte = {len_flag_r, par_flag_r, 6'h00};

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      SMSR_IDLE: if (cs_act) state_nxt = SMSR_FRAME;
      SMSR_FRAME: if (!cs_act) state_nxt = SMSR_IDLE;
    endcase
  end

  // state, bit counter and receive shifter
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_r <= SMSR_IDLE;
      cnt_r <= 6'h00;
      rx_r <= '0;
    end
    else if (soft_reset)
    begin
      state_r <= SMSR_IDLE;
      cnt_r <= 6'h00;
    end
    else
    begin
      state_r <= state_nxt;
      if (frame_start)
        cnt_r <= 6'h00;
      else if (sclk_rise && cs_act && cnt_r != SMSR_CNT_MAX)
        cnt_r <= cnt_r + 6'h01; // saturates so long frames stay wrong
      if (sclk_rise && cs_act)
        rx_r <= {rx_r[SMSR_FRAME_BITS-2:0], si_s_r[1]};
    end
  end

  // read data capture; writes fall on read-only space and are dropped
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_r <= '0;
    else if (soft_reset)
      rdata_r <= '0;
    else if (frame_ok)
      rdata_r <= is_write ? '0 : rd_val;
  end

  // error flags reported in the next frame; set wins over the report clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      len_flag_r <= 1'b0;
      par_flag_r <= 1'b0;
      len_err_r <= 1'b0;
      par_err_r <= 1'b0;
    end
    else
    begin
      len_flag_r <= len_bad || (len_flag_r && !frame_start && !soft_reset);
      par_flag_r <= par_bad || (par_flag_r && !frame_start && !soft_reset);
      len_err_r <= len_bad;
      par_err_r <= par_bad;
    end
  end

  // transmit shifter: loaded at frame start, next bit on each falling edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_r <= '0;
      so_r <= 1'b0;
    end
    else if (frame_start)
    begin
      tx_r <= {stat_byte, rdata_r};
      so_r <= stat_byte[7];
    end
    else if (sclk_fall && cs_act)
    begin
      tx_r <= {tx_r[SMSR_FRAME_BITS-2:0], 1'b0};
      so_r <= tx_r[SMSR_FRAME_BITS-2];
    end
  end

  assign spi_so = so_r;
  assign spi_so_oe = (state_r == SMSR_FRAME);
  assign frame_len_error = len_err_r;
  assign frame_par_error = par_err_r;

endmodule

// ### testbench/smsr_host_model.sv
// Purpose: serial host that clocks frames into the register bank
// Assumes: serial clock of 64 ns, idle low, stopped between frames
// Notes: samples read data at each of the first 32 rising serial edges, right after driving it
module smsr_host_model (
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_si,
  input wire logic spi_so
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_si = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // one frame of nbits clocks; only 32 is a legal length
  task automatic xfer(input logic [31:0] tx, input int nbits, output logic [31:0] rx);
    rx = 32'h00000000;
    #1.3 spi_cs_n = 1'b0;
    for (int i = 0; i < nbits; i++)
    begin
      spi_si = (i < 32) ? tx[31 - i] : 1'b0;
      #32 spi_sclk = 1'b1;
      if (i < 32)
        rx = {rx[30:0], spi_so}; // bits past a full word are not captured
      #32 spi_sclk = 1'b0;
    end
    #32 spi_cs_n = 1'b1;
    spi_si = ~spi_si; // released line must not keep a stale bit
    #40;
  endtask
endmodule

// ### testbench/smsr_status_regs_props.sv
// Purpose: port assertions of the status register bank
// Assumes: soft reset is only pulsed while no frame is open
// Notes: bound to every instance of the top module
module smsr_status_regs_props (
  input wire logic clk,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_so,
  input wire logic spi_so_oe,
  input wire logic frame_len_error,
  input wire logic frame_par_error
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////////
  // frame window follows chip select, allowing for the sync lag
  oe_idle_a: assert property (spi_cs_n [*6] |-> !spi_so_oe)
    else $error("output enable while deselected");
  oe_open_a: assert property ($fell(spi_cs_n) |-> ##[1:5] spi_so_oe)
    else $error("no output enable after select");
  // length error only after the frame closed; pulses one cycle each, never both
  len_closed_a: assert property (frame_len_error |-> spi_cs_n)
    else $error("length error inside frame");
  len_pulse_a: assert property (frame_len_error |=> !frame_len_error)
    else $error("length error longer than a cycle");
  par_pulse_a: assert property (frame_par_error |=> !frame_par_error)
    else $error("parity error longer than a cycle");
  err_excl_a: assert property (!(frame_len_error && frame_par_error))
    else $error("parity judged on a bad length frame");
  soft_clear_a: assert property (soft_reset |=> !spi_so_oe && !frame_len_error)
    else $error("soft reset left frame state");
  // read data only moves while the serial clock is low, after a fall
  so_shift_a: assert property (spi_so_oe && $past(spi_so_oe) && $changed(spi_so)
    |-> !$past(spi_sclk))
    else $error("read data moved on serial clock high");
  cover property ($rose(frame_len_error));
  cover property ($rose(frame_par_error));
  cover property ($fell(spi_so_oe));
endmodule
bind smsr_status_regs smsr_status_regs_props u_props (.clk(clk), .rstn(rstn),
  .soft_reset(soft_reset), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_so(spi_so),
  .spi_so_oe(spi_so_oe), .frame_len_error(frame_len_error),
  .frame_par_error(frame_par_error));

// ### testbench/switch_monitor_status_regs_test.sv
// Purpose: self-checking bench of the status register bank
// Assumes: host model reads each register with a following frame
// Notes: expected crc is folded by the bench itself
module switch_monitor_status_regs_test;
  import smsr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0, rstn = 1'b0, soft_reset = 1'b0, restart = 1'b0, valid = 1'b0;
  logic spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe, len_err, par_err;
  logic [3:0] live = 4'h0;
  logic [23:0] sw = 24'h000000, word = 24'h000000;
  logic [15:0] crc_exp = 16'hFFFF;
  logic [31:0] rx;
  int n_errors = 0, checked = 0, seed = 61145, n_len = 0, n_par = 0;
  always #2.5 clk = ~clk;
  smsr_status_regs u_smsr_status_regs (.clk(clk), .rstn(rstn), .soft_reset(soft_reset),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si), .spi_so(spi_so),
    .spi_so_oe(spi_so_oe), .supply_low_live(live[3]), .supply_high_live(live[2]),
    .heat_warning_live(live[1]), .heat_shutdown_live(live[0]), .switch_above(sw),
    .settings_restart(restart), .settings_valid(valid), .settings_word(word),
    .frame_len_error(len_err), .frame_par_error(par_err));
  smsr_host_model u_smsr_host_model (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_si(spi_si), .spi_so(spi_so));
  ////////////////////////////////////////////////////////////////
  // frame with odd parity over all 32 bits
  function automatic logic [31:0] mkf(logic wr, logic [5:0] a, logic [23:0] dt);
    logic [31:0] f;
    f = {wr, a, dt, 1'b0};
    f[0] = ~^f[31:1];
    return f;
  endfunction
  // host side crc, word folded msb first
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [23:0] w);
    for (int i = 23; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ w[i]) ? SMSR_CRC_POLY : 16'h0000);
    return c;
  endfunction
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd(logic [5:0] a);
    u_smsr_host_model.xfer(mkf(1'b0, a, 24'h000000), 32, rx);
    u_smsr_host_model.xfer(mkf(1'b0, 6'h00, 24'h000000), 32, rx);
  endtask
  task automatic fold(logic rs, logic [23:0] w);
    @(negedge clk);
    restart = rs;
    valid = 1'b1;
    word = w;
    @(negedge clk);
    restart = 1'b0;
    valid = 1'b0;
    crc_exp = rs ? 16'hFFFF : crc_step(crc_exp, w);
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // error pulses are counted as they fly past
  always @(posedge clk)
  begin
    if (len_err === 1'b1)
      n_len++;
    if (par_err === 1'b1)
      n_par++;
  end
  initial
  begin
    #400000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    report_and_stop;
  end
  initial
  begin
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    rd(SMSR_REG_CHECKSUM);
    chk(rx, 32'h0000FFFF);
    rd(SMSR_REG_LIVE);
    chk(rx, 32'h00000000);
    rd(SMSR_REG_THRESH);
    chk(rx, 32'h00000000);
    for (int i = 0; i < 6; i++)
    begin
      @(negedge clk);
      live = 4'($random(seed));
      sw = (i == 0) ? 24'h800001 : 24'($random(seed));
      fold(1'b0, 24'($random(seed)));
      fold(1'b0, 24'hFFFFFF);
      u_smsr_host_model.xfer(mkf(1'b1, 6'(3 + i % 3), 24'($random(seed))), 32, rx);
      rd(SMSR_REG_LIVE);
      chk(rx, {28'h0000000, live});
      rd(SMSR_REG_THRESH);
      chk(rx, {8'h00, sw});
      rd(SMSR_REG_CHECKSUM);
      chk(rx, {16'h0000, crc_exp});
    end
    u_smsr_host_model.xfer(32'h00000000, 31, rx);
    u_smsr_host_model.xfer(mkf(1'b0, SMSR_REG_LIVE, 24'h000000) ^ 32'h1, 32, rx);
    chk(32'(rx[31:30]), 32'h2);
    u_smsr_host_model.xfer(mkf(1'b0, SMSR_REG_LIVE, 24'h000000), 33, rx);
    chk(32'(rx[31:30]), 32'h1);
    rd(SMSR_REG_CHECKSUM);
    chk(rx, {16'h0000, crc_exp});
    chk(32'(n_len), 32'h2);
    chk(32'(n_par), 32'h1);
    rd(6'h3F);
    chk(rx, 32'h00000000);
    fold(1'b1, 24'h123456);
    rd(SMSR_REG_CHECKSUM);
    chk(rx, 32'h0000FFFF);
    fold(1'b0, 24'hA5A5A5);
    @(negedge clk);
    soft_reset = 1'b1;
    @(negedge clk);
    soft_reset = 1'b0;
    rd(SMSR_REG_CHECKSUM);
    chk(rx, 32'h0000FFFF);
    fold(1'b0, 24'h5A5A5A);
    rstn = 1'b0;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    rd(SMSR_REG_CHECKSUM);
    chk(rx, 32'h0000FFFF);
    report_and_stop;
  end
endmodule
